// *** rtl/smcc_top.v ***
// control-command handler of a serial memory device
// assumes link pins asynchronous, sampled on clock_i; mode 0 link
// Summary of operation
// RULE_01: write disable clears write enable latch
// RULE_02: latch zero refuses all latch-gated commands
// RULE_03: write disable ignored while write in progress
// RULE_04: opcode-only commands need select raised after byte
// RULE_05: quad mode opcodes arrive on four lines
// RULE_06: volatile enable marks next register write volatile
// RULE_07: clear status zeroes busy, latch, errors
// RULE_08: clear status needs no latch, works busy
// RULE_09: nv pattern program needs latch set
// RULE_10: nv program starts only after exact byte
// RULE_11: nv program shows busy, sets program error
// RULE_12: nv program end clears write enable latch
// RULE_13: host keeps pattern commands at 133 MHz max
// RULE_14: volatile pattern write needs latch, immediate
// RULE_15: pattern read: one dummy, then pattern out
// RULE_16: pattern repeats every eight further clocks; quad mode here repeats it every two clocks
// RULE_17: dummy cycle line values are ignored
// RULE_18: quad mode pattern read on four lines
// RULE_19: enter wide address sets length bit
// RULE_20: four-byte-only commands always use four bytes
// RULE_21: exit wide address clears length bit
// RULE_22: resets restore default; any-write may clear bit
// RULE_23: write enable sets write enable latch
// RULE_24: volatile-targeted write touches volatile regs only
// RULE_25: msb first, bit or nibble per clock
`timescale 1ns/1ps
`include "smcc_defines.vh"
module smcc_top #(
  parameter [31:0] PROG_NS = `SMCC_T_PROG_NS
) (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // serial link pins
  input wire cs_n_i,
  input wire sck_i,
  input wire [3:0] io_i,
  output wire [3:0] io_o,
  output wire [3:0] io_oe_o,
  // mode and outside events
  input wire quad_peripheral_mode_i,
  input wire embedded_busy_i,
  input wire program_fail_i,
  input wire erase_fail_i,
  input wire soft_reset_i,
  input wire nv_address_length_default_i,
  input wire any_register_clear_ads_i,
  input wire register_write_done_i,
  input wire four_byte_only_cmd_i,
  // status outputs
  output wire write_enable_latch_o,
  output wire write_in_progress_flag_o,
  output wire program_error_o,
  output wire erase_error_o,
  output wire address_length_bit_o,
  output wire four_address_bytes_o,
  output wire volatile_target_o,
  output wire write_permit_o,
  output wire [7:0] learning_pattern_o,
  output wire [7:0] nv_learning_pattern_o
);
  // program interval in cycles, rounded up
  localparam [31:0] PROG_CYC =
    (PROG_NS + `SMCC_CLK_NS - 32'd1) / `SMCC_CLK_NS;

  wire [5:0] pins_s; // synchronised {cs_n, sck, io}
  wire cs_n_s; // deselect level
  wire sck_s; // link clock level
  wire [3:0] io_s; // data lines
  wire prog_done; // nv program interval over
  reg sck_d_r; // previous link clock level
  reg cs_d_r; // previous deselect level
  reg [2:0] st_r; // frame state
  reg [2:0] cnt_r; // units of current byte
  reg [7:0] sh_r; // input shift
  reg [7:0] op_r; // latched opcode
  reg [7:0] dat_r; // latched data byte
  reg [2:0] rd_r; // read position in pattern
  reg [3:0] io_o_r; // line drive values
  reg [3:0] io_oe_r; // line enables
  reg latch_r; // write enable latch
  reg prog_r; // write in progress
  reg perr_r; // program error
  reg eerr_r; // erase error
  reg alen_r; // address length bit
  reg four_r; // four address bytes in use
  reg vtgt_r; // next register write goes volatile
  reg permit_r; // latch-gated commands allowed
  reg [7:0] pat_r; // volatile learning pattern
  reg [7:0] nvpat_r; // nonvolatile learning pattern
  reg [7:0] pend_r; // value being programmed
  reg nvrun_r; // nv program underway
  reg start_r; // one-cycle program start
  reg strap_r; // apply reset default after release

  wire rise = sck_s & ~sck_d_r; // sample edge
  wire fall = ~sck_s & sck_d_r; // drive edge
  wire frame_end = cs_n_s & ~cs_d_r; // deselect edge
  wire busy = prog_r | embedded_busy_i; // any embedded operation
  // last unit of a byte: 2 nibbles or 8 bits
  wire last = quad_peripheral_mode_i ? (cnt_r == 3'h1)
                                     : (cnt_r == 3'h7);
  // next shift value, msb first (see RULE_25) (see RULE_05)
  wire [7:0] sh_nxt = quad_peripheral_mode_i ? {sh_r[3:0], io_s}
                                             : {sh_r[6:0], io_s[0]};

  // pin synchroniser
  smcc_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i({cs_n_i, sck_i, io_i}),
    .sync_o(pins_s)
  );
  assign cs_n_s = pins_s[5];
  assign sck_s = pins_s[4];
  assign io_s = pins_s[3:0];

  // self-timed nv pattern program interval
  smcc_prog_timer #(
    .CYCLES(PROG_CYC)
  ) u_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(start_r),
    .done_o(prog_done)
  );

  // edge history of synchronised pins
  always @(posedge clock_i) begin
    if (rst_i) begin
      // match the synchroniser's reset level so no false edge follows
      sck_d_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
    end
  end

  // frame parser: opcode, data byte, dummy and read phases
  always @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= `SMCC_ST_OP;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      op_r <= 8'h00;
      dat_r <= 8'h00;
    end else if (cs_n_s) begin
      // deselected: ready for a new opcode
      st_r <= `SMCC_ST_OP;
      cnt_r <= 3'h0;
    end else if (rise) begin
      case (st_r)
        `SMCC_ST_OP: begin
          sh_r <= sh_nxt;
          cnt_r <= last ? 3'h0 : cnt_r + 3'h1;
          if (last) begin
            op_r <= sh_nxt;
            if (sh_nxt == `SMCC_OP_PRD) begin
              st_r <= `SMCC_ST_DUMMY;
            end else if (sh_nxt == `SMCC_OP_PNV ||
                         sh_nxt == `SMCC_OP_WPV) begin
              st_r <= `SMCC_ST_DATA;
            end else begin
              st_r <= `SMCC_ST_WAIT;
            end
          end
        end
        `SMCC_ST_DATA: begin
          sh_r <= sh_nxt;
          cnt_r <= last ? 3'h0 : cnt_r + 3'h1;
          if (last) begin
            dat_r <= sh_nxt;
            st_r <= `SMCC_ST_DWAIT;
          end
        end
        // line values ignored during latency (see RULE_17)
        `SMCC_ST_DUMMY: st_r <= `SMCC_ST_READ;
        `SMCC_ST_READ: st_r <= `SMCC_ST_READ;
        // a clock beyond the byte cancels the command (see RULE_04)
        `SMCC_ST_WAIT: st_r <= `SMCC_ST_DROP;
        `SMCC_ST_DWAIT: st_r <= `SMCC_ST_DROP; // see RULE_10
        `SMCC_ST_DROP: st_r <= `SMCC_ST_DROP;
        default: st_r <= `SMCC_ST_DROP;
      endcase
    end
  end

  // pattern output on falling edges, repeating per byte
  always @(posedge clock_i) begin
    if (rst_i) begin
      rd_r <= 3'h0;
      io_o_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else if (cs_n_s || st_r != `SMCC_ST_READ) begin
      // release the lines outside the read phase
      rd_r <= 3'h0;
      io_o_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else if (fall) begin
      if (quad_peripheral_mode_i) begin
        // nibble per clock on all four lines (see RULE_18)
        io_o_r <= rd_r[0] ? pat_r[3:0] : pat_r[7:4];
        io_oe_r <= 4'hF;
        rd_r <= {2'b00, ~rd_r[0]}; // see RULE_16
      end else begin
        // bit per clock on the output line (see RULE_15)
        io_o_r <= {2'b00, pat_r[3'h7 - rd_r], 1'b0};
        io_oe_r <= 4'h2;
        rd_r <= rd_r + 3'h1; // wraps each byte (see RULE_16)
      end
    end
  end

  // status flags, address length and patterns
  // one process owns every flag so that the priority between a set
  // and a clear in the same cycle is fixed by statement order alone
  always @(posedge clock_i) begin
    if (rst_i) begin
      latch_r <= 1'b0;
      prog_r <= 1'b0;
      perr_r <= 1'b0;
      eerr_r <= 1'b0;
      alen_r <= 1'b0;
      vtgt_r <= 1'b0;
      pat_r <= `SMCC_PAT_RST;
      nvpat_r <= `SMCC_NVPAT_RST;
      pend_r <= 8'h00;
      nvrun_r <= 1'b0;
      start_r <= 1'b0;
      strap_r <= 1'b1;
    end else begin
      // one-cycle strobes fall back by default
      start_r <= 1'b0;
      strap_r <= 1'b0;
      // length bit from nonvolatile default after reset (see RULE_22)
      // the default pin is read one cycle after release, not during
      // reset, so a strap that settles late is still honoured
      if (strap_r || soft_reset_i) begin
        alen_r <= nv_address_length_default_i;
      end else if (any_register_clear_ads_i) begin
        alen_r <= 1'b0; // see RULE_22
      end
      // volatile flag consumed by the register write (see RULE_24)
      if (register_write_done_i) begin
        vtgt_r <= 1'b0;
      end
      // commands act at deselect, never inside a frame
      if (frame_end && st_r == `SMCC_ST_WAIT) begin
        case (op_r)
          `SMCC_OP_WR_ENABLE: begin
            // accepted even while busy
            latch_r <= 1'b1; // see RULE_23
          end
          `SMCC_OP_WR_DISABLE: begin
            // an embedded operation keeps the latch (see RULE_03)
            if (!busy) begin
              latch_r <= 1'b0; // see RULE_01
            end
          end
          `SMCC_OP_VOL_ENABLE: begin
            // latch deliberately untouched
            vtgt_r <= 1'b1; // see RULE_06
          end
          `SMCC_OP_CLR_STATUS: begin
            // taken without latch, even while busy (see RULE_08)
            prog_r <= 1'b0; // see RULE_07
            latch_r <= 1'b0;
            perr_r <= 1'b0;
            eerr_r <= 1'b0;
          end
          `SMCC_OP_ENTER4: alen_r <= 1'b1; // see RULE_19
          `SMCC_OP_EXIT4: alen_r <= 1'b0; // see RULE_21
          default: ;
        endcase
      end
      // data commands gated by the latch (see RULE_02)
      if (frame_end && st_r == `SMCC_ST_DWAIT && latch_r && !busy) begin
        if (op_r == `SMCC_OP_PNV) begin
          // start self-timed program (see RULE_09) (see RULE_10)
          pend_r <= dat_r;
          nvrun_r <= 1'b1;
          start_r <= 1'b1;
          prog_r <= 1'b1; // see RULE_11
        end else if (op_r == `SMCC_OP_WPV) begin
          // the latch stays set; write disable, clear status or a program end clears it
          pat_r <= dat_r; // no busy time (see RULE_14)
        end
      end
      // program completion; a failure holds busy until cleared
      // a clear-status mid-program drops busy early, but the timer
      // still runs out and the latch is still cleared here
      if (prog_done && nvrun_r) begin
        nvrun_r <= 1'b0;
        latch_r <= 1'b0; // see RULE_12
        if (program_fail_i) begin
          perr_r <= 1'b1; // see RULE_11
        end else begin
          nvpat_r <= pend_r;
          prog_r <= 1'b0; // see RULE_11
        end
      end
      // outside failures set the flags; placed last so set wins
      if (program_fail_i && !nvrun_r) begin
        perr_r <= 1'b1;
      end
      if (erase_fail_i) begin
        eerr_r <= 1'b1;
      end
    end
  end

  // derived registered outputs
  // both lag their sources by one cycle, the price of flop outputs
  always @(posedge clock_i) begin
    if (rst_i) begin
      four_r <= 1'b0;
      permit_r <= 1'b0;
    end else begin
      four_r <= alen_r | four_byte_only_cmd_i; // see RULE_20
      permit_r <= latch_r & ~busy; // see RULE_02
    end
  end

  // every output comes straight from a flip-flop
  assign io_o = io_o_r;
  assign io_oe_o = io_oe_r;
  assign write_enable_latch_o = latch_r;
  assign write_in_progress_flag_o = prog_r;
  assign program_error_o = perr_r;
  assign erase_error_o = eerr_r;
  assign address_length_bit_o = alen_r;
  assign four_address_bytes_o = four_r;
  assign volatile_target_o = vtgt_r;
  assign write_permit_o = permit_r;
  assign learning_pattern_o = pat_r;
  assign nv_learning_pattern_o = nvpat_r;
endmodule // smcc_top

// *** rtl/smcc_defines.vh ***
// constants for the serial memory control-command handler
// assumes inclusion by bare name from the top module only
`ifndef SMCC_DEFINES_VH
`define SMCC_DEFINES_VH

// opcodes
`define SMCC_OP_WR_ENABLE 8'h06
`define SMCC_OP_WR_DISABLE 8'h04
`define SMCC_OP_VOL_ENABLE 8'h50
`define SMCC_OP_CLR_STATUS 8'h30
`define SMCC_OP_PNV 8'h43
`define SMCC_OP_WPV 8'h4A
`define SMCC_OP_PRD 8'h41
`define SMCC_OP_ENTER4 8'hB7
`define SMCC_OP_EXIT4 8'hE9

// status and config bit positions
`define SMCC_SR1_BUSY_BIT 0
`define SMCC_SR1_LATCH_BIT 1
`define SMCC_SR2_PERR 5
`define SMCC_SR2_EERR 6
`define SMCC_CR2_ALEN_BIT 0

// reset values
`define SMCC_PAT_RST 8'h00
`define SMCC_NVPAT_RST 8'h00

// self-timed pattern program time and clock
`define SMCC_T_PROG_NS 50000
`define SMCC_CLK_NS 10

// frame states
`define SMCC_ST_OP 3'h0
`define SMCC_ST_WAIT 3'h1
`define SMCC_ST_DATA 3'h2
`define SMCC_ST_DWAIT 3'h3
`define SMCC_ST_DUMMY 3'h4
`define SMCC_ST_READ 3'h5
`define SMCC_ST_DROP 3'h6

`endif

// *** rtl/smcc_sync.v ***
// two-stage synchroniser for the six link pins
// assumes pins are asynchronous to clock_i
`timescale 1ns/1ps
module smcc_sync (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // raw and synchronised pins
  input wire [5:0] async_i,
  output wire [5:0] sync_o
);
  reg [5:0] meta_r; // first stage, read by second stage only
  reg [5:0] sync_r; // second stage
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_bit
      // one pair of flip-flops per pin; resets high (idle deselect)
      always @(posedge clock_i) begin
        if (rst_i) begin
          meta_r[gi] <= 1'b1;
          sync_r[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= async_i[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate
  assign sync_o = sync_r;
endmodule // smcc_sync

// *** rtl/smcc_prog_timer.v ***
// self-timed program interval counter
// assumes start is a one-cycle pulse; done pulses once at expiry
`timescale 1ns/1ps
module smcc_prog_timer #(
  parameter [31:0] CYCLES = 32'd5000
) (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // control
  input wire start_i,
  output reg done_o
);
  reg [31:0] cnt_r; // cycles left
  reg run_r; // interval running
  // count down from CYCLES, pulse done at the end
  always @(posedge clock_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_r <= CYCLES - 32'h1;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == 32'h0) begin
          run_r <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 32'h1;
        end
      end
    end
  end
endmodule // smcc_prog_timer

// *** tb/smcc_asserts.sv ***
// concurrent checks on the control-command handler ports
// assumes one clock domain and the bind below
`timescale 1ns/1ps
module smcc_asserts (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // watched inputs
  input wire cs_n_i,
  input wire quad_peripheral_mode_i,
  input wire program_fail_i,
  input wire four_byte_only_cmd_i,
  // watched outputs
  input wire [3:0] io_oe_o,
  input wire write_enable_latch_o,
  input wire write_in_progress_flag_o,
  input wire program_error_o,
  input wire address_length_bit_o,
  input wire four_address_bytes_o,
  input wire volatile_target_o,
  input wire write_permit_o,
  input wire [7:0] nv_learning_pattern_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_oe_mode_shape: assert property (|io_oe_o |->
    io_oe_o == (quad_peripheral_mode_i ? 4'hF : 4'h2))
    else $error("drive enables do not match mode");
  a_oe_idle_off: assert property (
    cs_n_i [*8] |-> io_oe_o == 4'h0)
    else $error("lines driven while deselected");
  a_permit_latch: assert property (write_permit_o |->
    $past(write_enable_latch_o))
    else $error("write permitted without latch");
  a_addr_bytes: assert property (!$past(rst_i) |->
    four_address_bytes_o ==
    $past(address_length_bit_o | four_byte_only_cmd_i))
    else $error("address byte count wrong");
  a_busy_needs_latch: assert property (
    $rose(write_in_progress_flag_o) |-> write_enable_latch_o)
    else $error("program started without latch");
  a_busy_end_latch: assert property (
    $fell(write_in_progress_flag_o) |-> ##[0:1] !write_enable_latch_o)
    else $error("latch kept after program end");
  a_target_keeps: assert property (
    $rose(volatile_target_o) |-> $stable(write_enable_latch_o))
    else $error("volatile enable moved the latch");
  a_perr_cause: assert property ($rose(program_error_o) |->
    $past(program_fail_i) || $past(program_fail_i, 2))
    else $error("program error without failure");
  a_perr_clear: assert property ($fell(program_error_o) |->
    !write_in_progress_flag_o && !write_enable_latch_o)
    else $error("status clear incomplete");
  a_nv_end: assert property (!$stable(nv_learning_pattern_o) |->
    !write_enable_latch_o)
    else $error("stored pattern changed with latch set");
  a_latch_deselect: assert property (
    $rose(write_enable_latch_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("latch set inside a frame");
endmodule // smcc_asserts

bind smcc_top smcc_asserts smcc_asserts_inst (.clock_i, .rst_i, .cs_n_i,
  .quad_peripheral_mode_i, .program_fail_i, .four_byte_only_cmd_i,
  .io_oe_o, .write_enable_latch_o, .write_in_progress_flag_o,
  .program_error_o, .address_length_bit_o, .four_address_bytes_o,
  .volatile_target_o, .write_permit_o, .nv_learning_pattern_o);

// *** tb/smcc_host.sv ***
// behavioural serial host driving select, link clock and lines
// assumes mode 0 and an 80 ns link clock, idle low between frames
`timescale 1ns/1ps
module smcc_host (
  // link pins toward the device
  output reg cs_n_o,
  output reg sck_o,
  output reg [3:0] io_o,
  // mode and resolved lines
  input wire quad_i,
  input wire [3:0] line_i
);
  integer i; // bit loop index
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'h5;
  end
  // one link clock, 80 ns keeps well under 133 MHz
  task pulse;
    #40 sck_o = 1'b1;
    #40 sck_o = 1'b0;
  endtask
  // msb first; unused lines flip so stale values never pass
  task put(input [7:0] b);
    if (quad_i) begin
      io_o = b[7:4];
      pulse;
      io_o = b[3:0];
      pulse;
    end else begin
      for (i = 7; i >= 0; i = i - 1) begin
        io_o = {~io_o[3:1], b[i]};
        pulse;
      end
    end
  endtask
  // whole frame; ex adds stray clocks to break the count
  task frame(input [7:0] op, input integer nd, input [7:0] d,
    input integer ex);
    cs_n_o = 1'b0;
    put(op);
    repeat (nd) put(d);
    repeat (ex) pulse;
    #40 cs_n_o = 1'b1;
    io_o = ~io_o;
    #80;
  endtask
  // pattern read, two groups; lines toggle through the dummy
  task rd(output [15:0] got);
    cs_n_o = 1'b0;
    put(8'h41);
    io_o = ~io_o;
    pulse;
    got = 16'h0;
    for (i = 0; i < (quad_i ? 4 : 16); i = i + 1) begin
      #40 sck_o = 1'b1;
      io_o = ~io_o;
      #39 got = quad_i ? {got[11:0], line_i} : {got[14:0], line_i[1]};
      #1 sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    #80;
  endtask
endmodule // smcc_host

// *** tb/smcc_top_tb.sv ***
// self-checking bench: host model, flag model, comparisons
// assumes a shortened program time of 400 ns
`timescale 1ns/1ps
module smcc_top_tb;
  reg clock_i = 1'b0; // 100 MHz system clock
  reg rst_i = 1'b1; // synchronous reset
  reg qm = 1'b0, eb = 1'b0, pf = 1'b0, ef = 1'b0, sr = 1'b0;
  reg dflt = 1'b0, arc = 1'b0, rwd = 1'b0, fbo = 1'b0;
  wire cs_n, sck, latch, prog, perr, eerr, alb, fab, vt, wp;
  wire [3:0] hio, io_o, io_oe_o, io_w;
  wire [7:0] pat, nvp;
  // flag model
  reg m_latch = 1'b0, m_prog = 1'b0, m_perr = 1'b0, m_eerr = 1'b0;
  reg m_alb = 1'b0, m_vt = 1'b0;
  reg [7:0] m_pat = 8'h00, m_nvp = 8'h00, d;
  reg [15:0] got;
  integer errors = 0, n_compared = 0, seed = 32'h79b5faf3, m;
  // device drive wins wherever it enables a line
  assign io_w = (io_oe_o & io_o) | (~io_oe_o & hio);
  initial forever #5 clock_i = ~clock_i;
  smcc_host smcc_host_inst (.cs_n_o(cs_n), .sck_o(sck), .io_o(hio),
    .quad_i(qm), .line_i(io_w));
  smcc_top #(.PROG_NS(32'd400)) smcc_top_inst (.clock_i(clock_i),
    .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .io_i(io_w), .io_o(io_o),
    .io_oe_o(io_oe_o), .quad_peripheral_mode_i(qm), .embedded_busy_i(eb),
    .program_fail_i(pf), .erase_fail_i(ef), .soft_reset_i(sr),
    .nv_address_length_default_i(dflt), .any_register_clear_ads_i(arc),
    .register_write_done_i(rwd), .four_byte_only_cmd_i(fbo),
    .write_enable_latch_o(latch), .write_in_progress_flag_o(prog),
    .program_error_o(perr), .erase_error_o(eerr),
    .address_length_bit_o(alb), .four_address_bytes_o(fab),
    .volatile_target_o(vt), .write_permit_o(wp),
    .learning_pattern_o(pat), .nv_learning_pattern_o(nvp));
  task chk(input string nm, input [15:0] s, input [15:0] e);
    n_compared = n_compared + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task step;
    @(posedge clock_i);
    #1;
  endtask
  // random four-byte-only input, then whole state against model
  task all;
    fbo = $random(seed);
    repeat (3) step;
    chk("flags", {latch, prog, perr, eerr, alb, vt, fab}, {m_latch, m_prog,
      m_perr, m_eerr, m_alb, m_vt, m_alb | fbo});
    chk("patterns", {pat, nvp}, {m_pat, m_nvp});
  endtask
  task cmd(input [7:0] op, input integer nd, input [7:0] dd,
    input integer ex);
    smcc_host_inst.frame(op, nd, dd, ex);
    all;
  endtask
  task end_of_test;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the two mode passes
  initial begin
    #200000;
    errors = errors + 1;
    end_of_test;
  end
  initial begin
    repeat (8) step;
    rst_i = 1'b0;
    all;
    for (m = 0; m < 2; m = m + 1) begin
      qm = m;
      m_latch = 1'b1;
      cmd(8'h06, 0, 0, 0);
      m_latch = 1'b0;
      cmd(8'h04, 0, 0, 0);
      cmd(8'h06, 0, 0, 1);
      d = $random(seed);
      cmd(8'h4A, 1, d, 0);
      m_latch = 1'b1;
      cmd(8'h06, 0, 0, 0);
      m_pat = d;
      cmd(8'h4A, 1, d, 0);
      cmd(8'h4A, 2, ~d, 0);
      m_vt = 1'b1;
      cmd(8'h50, 0, 0, 0);
      rwd = 1'b1;
      step;
      rwd = 1'b0;
      m_vt = 1'b0;
      all;
      smcc_host_inst.rd(got);
      chk("read", got, {m_pat, m_pat});
      eb = 1'b1;
      cmd(8'h04, 0, 0, 0);
      eb = 1'b0;
      d = $random(seed);
      cmd(8'h43, 2, d, 0);
      m_prog = 1'b1;
      cmd(8'h43, 1, d, 0);
      repeat (50) step;
      {m_prog, m_latch, m_nvp} = {2'b00, d};
      all;
      cmd(8'h43, 1, ~d, 0);
      m_latch = 1'b1;
      cmd(8'h06, 0, 0, 0);
      smcc_host_inst.frame(8'h43, 1, m_nvp, 0);
      // failure raised only once the program runs
      pf = 1'b1;
      repeat (50) step;
      pf = 1'b0;
      chk("failed program", {perr, prog}, 2'b11);
      ef = 1'b1;
      step;
      ef = 1'b0;
      {m_latch, m_prog} = 2'b00;
      cmd(8'h30, 0, 0, 0);
      m_alb = 1'b1;
      cmd(8'hB7, 0, 0, 0);
      arc = 1'b1;
      step;
      arc = 1'b0;
      m_alb = 1'b0;
      all;
      m_alb = 1'b1;
      cmd(8'hB7, 0, 0, 0);
      m_alb = 1'b0;
      cmd(8'hE9, 0, 0, 0);
    end
    dflt = 1'b1;
    rst_i = 1'b1;
    repeat (8) step;
    rst_i = 1'b0;
    {m_latch, m_prog, m_perr, m_eerr, m_vt, m_alb} = 6'h01;
    {m_pat, m_nvp} = 16'h0000;
    all;
    dflt = 1'b0;
    sr = 1'b1;
    step;
    sr = 1'b0;
    m_alb = 1'b0;
    all;
    end_of_test;
  end
endmodule // smcc_top_tb
